// *** include/power_mode_pkg.sv ***
// ====================================================================
// Shared constants for the power mode and wake-up controller
package power_mode_pkg;

   // ====================================================================
   // Register byte offsets
   localparam logic [7:0] OFS_LOW_CRYSTAL = 8'h00;
   localparam logic [7:0] OFS_SYS_CLOCK = 8'h04;
   localparam logic [7:0] OFS_HIGH_CRYSTAL = 8'h08;
   localparam logic [7:0] OFS_HIGH_INTERNAL = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_PA_WAKE = 8'h14;
   localparam logic [7:0] OFS_WAKE_CAUSE = 8'h18;

   // ====================================================================
   // Field positions
   localparam int LXC_EN_BIT = 0;
   localparam int LXC_STABLE_BIT = 1;
   localparam int LXC_ONE_BIT = 2;
   localparam int SYS_SEL_LSB = 5;
   localparam int SYS_FSRC_BIT = 3;
   localparam int SYS_SSRC_BIT = 2;
   localparam int SYS_FIDLE_BIT = 1;
   localparam int SYS_SIDLE_BIT = 0;
   localparam int HXC_EN_BIT = 0;
   localparam int HXC_STABLE_BIT = 1;
   localparam int HXC_MODE_BIT = 2;
   localparam int HIC_EN_BIT = 0;
   localparam int HIC_STABLE_BIT = 1;
   localparam int HIC_FSEL_LSB = 2;
   localparam int ST_PD_BIT = 0;
   localparam int ST_TO_BIT = 1;

   // ====================================================================
   // Reset values and encodings
   localparam logic [7:0] SYS_RESET = 8'h00;
   localparam logic [7:0] HIC_RESET = 8'h01;
   localparam logic [2:0] SEL_SLOW = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] OSC_FINT = 2'h0;
   localparam logic [1:0] OSC_FXTL = 2'h1;
   localparam logic [1:0] OSC_SINT = 2'h2;
   localparam logic [1:0] OSC_SXTL = 2'h3;

   // ====================================================================
   // Oscillator settling times and cycle counts at 10 MHz
   localparam int CLK_PERIOD_NS = 100;
   localparam int SXTL_SETTLE_NS = 1000000;
   localparam int FXTL_SETTLE_NS = 200000;
   localparam int FINT_SETTLE_NS = 20000;
   localparam int SINT_SETTLE_NS = 10000;
   localparam int SXTL_SETTLE_CYC = (SXTL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FXTL_SETTLE_CYC = (FXTL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FINT_SETTLE_CYC = (FINT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SINT_SETTLE_CYC = (SINT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Power sequencing states
   typedef enum logic [2:0] {
      PS_RUN = 3'b001,
      PS_DOWN = 3'b010,
      PS_WAKE = 3'b100
   } pwr_state_type;

endpackage : power_mode_pkg

// *** core/osc_settle.sv ***
`timescale 1ns/1ns
// ====================================================================
// Oscillator start-up model: stable flag after a settling count
module osc_settle #(
   parameter int SETTLE_CYCLES = 100
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic run,
   input wire logic restart,
   output logic stable_q
);
   localparam int CW = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES);

   logic run_q;
   logic [CW-1:0] cnt_q;

   // Flag drops on disable or restart, rises when count completes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= 1'b0;
         cnt_q <= '0;
         stable_q <= 1'b0;
      end else if (ce) begin
         run_q <= run;
         if (!run || restart || !run_q) begin
            cnt_q <= '0;
            stable_q <= 1'b0;
         end else if (cnt_q == LAST - CW'(1)) begin
            stable_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + CW'(1);
         end
      end
   end

endmodule : osc_settle

// *** core/power_mode_ctrl.sv ***
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
// ====================================================================
// Overview of operation
// R1: Enabling the low crystal clears its stable flag, then sets it once settled.
// R2: Low crystal control bit 0 enables that oscillator; resets to zero.
// R3: Low crystal control bits 7..3 read zero, bit 2 one, bit 1 read-only.
// R4: Clock select 111 moves the system clock to the slow source.
// R5: Slow source is low crystal or low internal, switched only once stable.
// R6: Clock select 000..110 runs from fast clock divided by 1 to 64.
// R7: Return to fast mode waits for the fast oscillator to restart.
// R8: Halt with both idle enables zero enters sleep, all clocks stopped.
// R9: Halt with fast idle 0, slow idle 1 enters idle zero.
// R10: Halt with both idle enables one enters idle one, both clocks run.
// R11: Halt with fast idle 1, slow idle 0 enters idle two.
// R12: Power down keeps memory, registers and ports; execution holds at halt.
// R13: Power down entry sets the power down flag, clears time-out flag.
// R14: Power down entry clears the watchdog counter.
// R15: Wake on reset pin, enabled port A fall, interrupt or watchdog overflow.
// R16: Pin wake does full reset; watchdog wake sets time-out, resets PC and SP.
// R17: Power down flag clears on power-up or clear watchdog, sets on halt.
// R18: Per-pin port A wake enable; wake resumes after the halt.
// R19: Disabled interrupt or full stack resumes after halt, service deferred.
// R20: Enabled interrupt with free stack gets the regular interrupt response.
// R21: Interrupt already pending at power down entry cannot wake the device.
// R22: Internal fast oscillator enable or frequency change restarts its stable flag.
// R23: Wake-up holds execution until the system clock oscillator is stable.
module power_mode_ctrl
   import power_mode_pkg::*;
#(
   parameter int PA_W = 8,
   parameter int IRQ_W = 8,
   parameter int SXTL_SETTLE_CYCLES = power_mode_pkg::SXTL_SETTLE_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic halt_exec,
   input wire logic clr_wdt,
   input wire logic wdt_overflow,
   input wire logic [IRQ_W-1:0] irq_flag,
   input wire logic [IRQ_W-1:0] irq_enable,
   input wire logic stack_full,
   input wire logic [PA_W-1:0] port_a_pin,
   input wire logic external_reset_pin_n,
   output logic cpu_halt_q,
   output logic sys_slow_q,
   output logic [2:0] sys_div_q,
   output logic [1:0] sys_src_q,
   output logic fh_clk_en_q,
   output logic fsub_clk_en_q,
   output logic wdt_clear_q,
   output logic resume_q,
   output logic irq_take_q,
   output logic pc_sp_reset_q,
   output logic full_reset_q
);
   import power_mode_pkg::*;

   // ====================================================================
   // Register state
   logic low_crystal_enable_q;
   logic [7:0] system_clock_control_reg_q;
   logic [7:0] high_crystal_control_reg_q;
   logic [7:0] high_internal_control_reg_q;
   logic [PA_W-1:0] port_a_wake_enable_q;
   logic power_down_flag_q;
   logic watchdog_timeout_flag_q;
   logic [4:0] wake_cause_q;
   logic fint_restart_q;

   // Bus handshake state
   logic aw_full_q;
   logic w_full_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   logic wr_fire;
   logic wr_lane;

   // Power sequencing state
   pwr_state_type state_q;
   logic [1:0] idle_mode_q;
   logic [IRQ_W-1:0] irq_armed_q;
   logic [4:0] pending_q;

   // Synchronisers and oscillator status
   logic [PA_W-1:0] pa_s1_q;
   logic [PA_W-1:0] pa_s2_q;
   logic [PA_W-1:0] pa_prev_q;
   logic rst_s1_q;
   logic rst_s2_q;
   logic [3:0] osc_run;
   logic [3:0] osc_restart;
   logic [3:0] osc_stable;

   // Decoded controls and wake sources
   logic [2:0] csel;
   logic fh_allowed;
   logic fsub_allowed;
   logic halt_entry;
   logic pa_wake;
   logic irq_wake;
   logic irq_service;
   logic [1:0] target_src;
   logic [7:0] rd_val;
   logic rd_hit;

   assign csel = system_clock_control_reg_q[SYS_SEL_LSB +: 3];
   assign halt_entry = (state_q == PS_RUN) && halt_exec;
   assign wr_fire = aw_full_q && w_full_q && !bvalid;
   assign wr_lane = wr_fire && wstrb0_q;

   // ====================================================================
   // Write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb0_q <= 1'b0;
      end else if (ce) begin
         awready <= !aw_full_q && !(awvalid && awready);
         wready <= !w_full_q && !(wvalid && wready);
         if (awvalid && awready) begin
            aw_full_q <= 1'b1;
            awaddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_full_q <= 1'b1;
            wdata_q <= wdata;
            wstrb0_q <= wstrb[0];
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= OFS_WAKE_CAUSE) ? RESP_OKAY
                                                                           : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ====================================================================
   // Software-writable control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_crystal_enable_q <= 1'b0;                                          // [R2]
         system_clock_control_reg_q <= SYS_RESET;
         high_crystal_control_reg_q <= 8'h00;
         high_internal_control_reg_q <= HIC_RESET;
         port_a_wake_enable_q <= '0;
         fint_restart_q <= 1'b0;
      end else if (ce) begin
         fint_restart_q <= 1'b0;
         if (wr_lane) begin
            unique case (awaddr_q)
               OFS_LOW_CRYSTAL: low_crystal_enable_q <= wdata_q[LXC_EN_BIT];    // [R2]
               OFS_SYS_CLOCK: system_clock_control_reg_q <= {wdata_q[7:5], 1'b0,
                                                              wdata_q[3:0]};
               OFS_HIGH_CRYSTAL: begin
                  high_crystal_control_reg_q[HXC_EN_BIT] <= wdata_q[HXC_EN_BIT];
                  high_crystal_control_reg_q[HXC_MODE_BIT] <= wdata_q[HXC_MODE_BIT];
               end
               OFS_HIGH_INTERNAL: begin
                  high_internal_control_reg_q[HIC_EN_BIT] <= wdata_q[HIC_EN_BIT];
                  high_internal_control_reg_q[HIC_FSEL_LSB +: 2] <=
                     wdata_q[HIC_FSEL_LSB +: 2];
                  // Frequency change restarts settling
                  fint_restart_q <= wdata_q[HIC_FSEL_LSB +: 2] !=
                                    high_internal_control_reg_q[HIC_FSEL_LSB +: 2]; // [R22]
               end
               OFS_PA_WAKE: port_a_wake_enable_q <= wdata_q[PA_W-1:0];          // [R18]
               default: ;
            endcase
         end
      end
   end

   // ====================================================================
   // Read data mux
   always_comb begin
      rd_val = 8'h00;
      rd_hit = 1'b1;
      unique case (araddr)
         OFS_LOW_CRYSTAL: begin
            rd_val[LXC_ONE_BIT] = 1'b1;                                         // [R3]
            rd_val[LXC_STABLE_BIT] = osc_stable[OSC_SXTL];                      // [R3]
            rd_val[LXC_EN_BIT] = low_crystal_enable_q;
         end
         OFS_SYS_CLOCK: rd_val = system_clock_control_reg_q;
         OFS_HIGH_CRYSTAL: begin
            rd_val = high_crystal_control_reg_q;
            rd_val[HXC_STABLE_BIT] = osc_stable[OSC_FXTL];
         end
         OFS_HIGH_INTERNAL: begin
            rd_val = high_internal_control_reg_q;
            rd_val[HIC_STABLE_BIT] = osc_stable[OSC_FINT];
         end
         OFS_STATUS: begin
            rd_val[ST_PD_BIT] = power_down_flag_q;
            rd_val[ST_TO_BIT] = watchdog_timeout_flag_q;
         end
         OFS_PA_WAKE: rd_val[PA_W-1:0] = port_a_wake_enable_q;
         OFS_WAKE_CAUSE: rd_val[4:0] = wake_cause_q;
         default: rd_hit = 1'b0;
      endcase
   end

   // Read channel, one word per address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_val};
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end else if (!rvalid) begin
            arready <= 1'b1;
         end
      end
   end

   // ====================================================================
   // Pin synchronisers and port A falling edge detect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pa_s1_q <= '1;
         pa_s2_q <= '1;
         pa_prev_q <= '1;
         rst_s1_q <= 1'b1;
         rst_s2_q <= 1'b1;
      end else if (ce) begin
         pa_s1_q <= port_a_pin;
         pa_s2_q <= pa_s1_q;
         pa_prev_q <= pa_s2_q;
         rst_s1_q <= external_reset_pin_n;
         rst_s2_q <= rst_s1_q;
      end
   end

   assign pa_wake = |(pa_prev_q & ~pa_s2_q & port_a_wake_enable_q);            // [R18]
   assign irq_wake = |(irq_flag & irq_armed_q);                                // [R21]
   assign irq_service = |(irq_flag & irq_armed_q & irq_enable) && !stack_full; // [R20]

   // ====================================================================
   // Oscillator enables by power state and idle mode
   always_comb begin
      fh_allowed = (state_q != PS_DOWN) || idle_mode_q[1];                     // [R8]
      fsub_allowed = (state_q != PS_DOWN) || idle_mode_q[0];                   // [R9]
      osc_run[OSC_FINT] = high_internal_control_reg_q[HIC_EN_BIT] && fh_allowed;
      osc_run[OSC_FXTL] = high_crystal_control_reg_q[HXC_EN_BIT] && fh_allowed;
      osc_run[OSC_SINT] = 1'b1;
      osc_run[OSC_SXTL] = low_crystal_enable_q && fsub_allowed;                 // [R1]
      osc_restart = {3'b000, fint_restart_q};                                   // [R22]
   end

   // One settling model per oscillator
   for (genvar i = 0; i < 4; i++) begin : g_osc
      localparam int CYC = (i == OSC_SXTL) ? SXTL_SETTLE_CYCLES :
                           (i == OSC_FXTL) ? FXTL_SETTLE_CYC :
                           (i == OSC_FINT) ? FINT_SETTLE_CYC : SINT_SETTLE_CYC;
      osc_settle #(.SETTLE_CYCLES(CYC)) u_osc (
         .aclk(aclk),
         .aresetn(aresetn),
         .ce(ce),
         .run(osc_run[i]),
         .restart(osc_restart[i]),
         .stable_q(osc_stable[i])
      );
   end

   // ====================================================================
   // System clock source: switch only to a stable oscillator
   always_comb begin
      if (csel == SEL_SLOW) begin
         target_src = system_clock_control_reg_q[SYS_SSRC_BIT] ? OSC_SXTL : OSC_SINT; // [R5]
      end else begin
         target_src = system_clock_control_reg_q[SYS_FSRC_BIT] ? OSC_FXTL : OSC_FINT;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_slow_q <= 1'b0;
         sys_div_q <= 3'h0;
         sys_src_q <= OSC_FINT;
         fh_clk_en_q <= 1'b1;
         fsub_clk_en_q <= 1'b1;
      end else if (ce) begin
         fh_clk_en_q <= fh_allowed;                                             // [R10]
         fsub_clk_en_q <= fsub_allowed;                                         // [R11]
         if (state_q == PS_RUN && osc_stable[target_src]) begin                 // [R7]
            sys_src_q <= target_src;
            sys_slow_q <= csel == SEL_SLOW;                                     // [R4]
            if (csel != SEL_SLOW) begin
               sys_div_q <= csel;                                               // [R6]
            end
         end
      end
   end

   // ====================================================================
   // Power down, wake-up sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= PS_RUN;
         idle_mode_q <= 2'b00;
         irq_armed_q <= '0;
         pending_q <= 5'h00;
         wake_cause_q <= 5'h00;
         cpu_halt_q <= 1'b0;
         wdt_clear_q <= 1'b0;
         resume_q <= 1'b0;
         irq_take_q <= 1'b0;
         pc_sp_reset_q <= 1'b0;
         full_reset_q <= 1'b0;
      end else if (ce) begin
         wdt_clear_q <= 1'b0;
         resume_q <= 1'b0;
         irq_take_q <= 1'b0;
         pc_sp_reset_q <= 1'b0;
         full_reset_q <= 1'b0;
         unique case (state_q)
            PS_RUN: begin
               if (halt_exec) begin
                  state_q <= PS_DOWN;
                  idle_mode_q <= {system_clock_control_reg_q[SYS_FIDLE_BIT],
                                  system_clock_control_reg_q[SYS_SIDLE_BIT]}; // [R8]
                  irq_armed_q <= ~irq_flag;                                     // [R21]
                  cpu_halt_q <= 1'b1;                                           // [R12]
                  wdt_clear_q <= 1'b1;                                          // [R14]
               end
            end
            PS_DOWN: begin
               // Priority: pin reset, watchdog, port A, interrupt
               if (!rst_s2_q) begin
                  pending_q <= 5'b00001;                                        // [R16]
               end else if (wdt_overflow) begin
                  pending_q <= 5'b00010;                                        // [R16]
               end else if (pa_wake) begin
                  pending_q <= 5'b00100;                                        // [R18]
               end else if (irq_service) begin
                  pending_q <= 5'b01000;                                        // [R20]
               end else if (irq_wake) begin
                  pending_q <= 5'b10000;                                        // [R19]
               end
               if (!rst_s2_q || wdt_overflow || pa_wake || irq_wake) begin      // [R15]
                  state_q <= PS_WAKE;
               end
            end
            PS_WAKE: begin
               if (osc_stable[sys_src_q]) begin                                 // [R23]
                  state_q <= PS_RUN;
                  cpu_halt_q <= 1'b0;
                  wake_cause_q <= pending_q;
                  full_reset_q <= pending_q[0];                                 // [R16]
                  pc_sp_reset_q <= pending_q[1];                                // [R16]
                  resume_q <= pending_q[2] || pending_q[4];                     // [R19]
                  irq_take_q <= pending_q[3];                                   // [R20]
               end
            end
            default: state_q <= PS_RUN;
         endcase
      end
   end

   // ====================================================================
   // Status flags: set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_down_flag_q <= 1'b0;                                             // [R17]
         watchdog_timeout_flag_q <= 1'b0;
      end else if (ce) begin
         if (halt_entry) begin
            power_down_flag_q <= 1'b1;                                          // [R13]
         end else if (clr_wdt) begin
            power_down_flag_q <= 1'b0;                                          // [R17]
         end
         if (wdt_overflow) begin
            watchdog_timeout_flag_q <= 1'b1;                                    // [R16]
         end else if (halt_entry) begin
            watchdog_timeout_flag_q <= 1'b0;                                    // [R13]
         end
      end
   end

endmodule : power_mode_ctrl

// *** tb/power_mode_ctrl_asserts.sv ***
`timescale 1ns/1ns
// ====================================================================
// Port checks for the power mode controller
module power_mode_ctrl_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic halt_exec,
   input wire logic cpu_halt_q,
   input wire logic wdt_clear_q,
   input wire logic resume_q,
   input wire logic irq_take_q,
   input wire logic pc_sp_reset_q,
   input wire logic full_reset_q,
   input wire logic sys_slow_q,
   input wire logic [2:0] sys_div_q
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Halt request taken while running
   sequence s_halt_taken;
      halt_exec && !cpu_halt_q && ce;
   endsequence
   // End of a wake sequence
   sequence s_wake_end;
      $fell(cpu_halt_q);
   endsequence
   a_halt_entry: assert property (s_halt_taken |=> cpu_halt_q && wdt_clear_q)
      else $error("halt not entered");
   a_clear_single: assert property (wdt_clear_q |=> !wdt_clear_q)
      else $error("watchdog clear too long");
   a_clear_cause: assert property (wdt_clear_q |-> $past(halt_exec) && !$past(cpu_halt_q))
      else $error("watchdog clear without halt");
   a_resume_exit: assert property (resume_q |-> !cpu_halt_q && $past(cpu_halt_q))
      else $error("resume outside wake");
   a_irq_exit: assert property (irq_take_q |-> $past(cpu_halt_q))
      else $error("interrupt take outside wake");
   a_one_cause: assert property ($onehot0({resume_q, irq_take_q, pc_sp_reset_q, full_reset_q}))
      else $error("several wake pulses");
   a_wake_pulse: assert property (s_wake_end |-> resume_q || irq_take_q || pc_sp_reset_q
      || full_reset_q)
      else $error("wake without pulse");
   a_div_range: assert property (sys_div_q <= 3'h6)
      else $error("divider out of range");
   a_slow_div_hold: assert property (sys_slow_q && $past(sys_slow_q) |-> $stable(sys_div_q))
      else $error("divider moved in slow mode");
endmodule : power_mode_ctrl_asserts
bind power_mode_ctrl power_mode_ctrl_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
   .halt_exec(halt_exec), .cpu_halt_q(cpu_halt_q), .wdt_clear_q(wdt_clear_q),
   .resume_q(resume_q), .irq_take_q(irq_take_q), .pc_sp_reset_q(pc_sp_reset_q),
   .full_reset_q(full_reset_q), .sys_slow_q(sys_slow_q), .sys_div_q(sys_div_q));

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
// ====================================================================
// Register and power sequencing bench
module tb_top;
   import power_mode_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic halt_exec = 1'b0, clr_wdt = 1'b0, wdt_ovf = 1'b0, rst_pin_n = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, port_a_pin = 8'hFF;
   logic [7:0] irq_flag = 8'h00, irq_enable = 8'h00, rd_q;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, cpu_halt_q, sys_slow_q, fh_clk_en_q;
   logic fsub_clk_en_q, wdt_clear_q, resume_q, irq_take_q, pc_sp_reset_q, full_reset_q;
   logic [1:0] bresp, rresp, sys_src_q;
   logic [2:0] sys_div_q;
   logic [31:0] rdata;
   int failures = 0;
   int check_count = 0;
   // Clock
   always #50 aclk = ~aclk;
   power_mode_ctrl #(.SXTL_SETTLE_CYCLES(20)) u_dut (.aclk, .aresetn, .ce(1'b1), .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .halt_exec, .clr_wdt,
      .wdt_overflow(wdt_ovf), .irq_flag, .irq_enable, .stack_full(1'b0), .port_a_pin,
      .external_reset_pin_n(rst_pin_n), .cpu_halt_q, .sys_slow_q, .sys_div_q, .sys_src_q,
      .fh_clk_en_q, .fsub_clk_en_q, .wdt_clear_q, .resume_q, .irq_take_q, .pc_sp_reset_q,
      .full_reset_q);
   // Bus write, waits for the response
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr
   // Bus read, low byte into rd_q
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd_q = rdata[7:0];
      rready <= 1'b0;
   endtask : rd
   // Compare and count
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Halt with given idle enables, check clocks and status
   task automatic hlt(input logic [1:0] m);
      wr(OFS_SYS_CLOCK, {6'h00, m});
      halt_exec <= 1'b1;
      @(posedge aclk);
      halt_exec <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("halted", 8'h01, {7'h0, cpu_halt_q});
      chk("fast_en", {7'h0, m[1]}, {7'h0, fh_clk_en_q});
      chk("slow_en", {7'h0, m[0]}, {7'h0, fsub_clk_en_q});
      rd(OFS_STATUS);
      chk("status", 8'h01, rd_q);
   endtask : hlt
   // Port A falling edge wake
   task automatic pa_wake();
      port_a_pin <= 8'hFE;
      do @(posedge aclk); while (resume_q !== 1'b1);
      port_a_pin <= 8'hFF;
   endtask : pa_wake
   // Verdict
   task automatic results();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   // Watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      results();
   end
   // Test sequence
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (250) @(posedge aclk);
      rd(OFS_LOW_CRYSTAL);
      chk("lxc_reset", 8'h04, rd_q);
      rd(8'h40);
      chk("unmapped", {6'h0, RESP_SLVERR}, {6'h0, rresp});
      wr(OFS_LOW_CRYSTAL, 8'h01);
      rd(OFS_LOW_CRYSTAL);
      chk("sxtl_settling", 8'h05, rd_q);
      repeat (30) @(posedge aclk);
      rd(OFS_LOW_CRYSTAL);
      chk("sxtl_stable", 8'h07, rd_q);
      wr(OFS_LOW_CRYSTAL, 8'hF9);
      rd(OFS_LOW_CRYSTAL);
      chk("lxc_fixed", 8'h07, rd_q);
      $display("test oscillator done");
      for (int k = 0; k < 7; k++) begin
         wr(OFS_SYS_CLOCK, {k[2:0], 5'h00});
         repeat (2) @(posedge aclk);
         chk("divider", {5'h0, k[2:0]}, {5'h0, sys_div_q});
      end
      wr(OFS_SYS_CLOCK, 8'hE4);
      repeat (2) @(posedge aclk);
      chk("slow", 8'h01, {7'h0, sys_slow_q});
      chk("slow_src", {6'h0, OSC_SXTL}, {6'h0, sys_src_q});
      wr(OFS_SYS_CLOCK, 8'h00);
      repeat (2) @(posedge aclk);
      chk("fast", 8'h00, {7'h0, sys_slow_q});
      $display("test clock switch done");
      wr(OFS_PA_WAKE, 8'h01);
      for (int m = 0; m < 4; m++) begin
         hlt(m[1:0]);
         pa_wake();
      end
      irq_enable <= 8'h01;
      irq_flag <= 8'h01;
      hlt(2'h3);
      repeat (50) @(posedge aclk);
      chk("pending_irq", 8'h01, {7'h0, cpu_halt_q});
      pa_wake();
      irq_flag <= 8'h00;
      hlt(2'h3);
      irq_flag <= 8'h01;
      do @(posedge aclk); while (irq_take_q !== 1'b1);
      irq_flag <= 8'h00;
      clr_wdt <= 1'b1;
      @(posedge aclk);
      clr_wdt <= 1'b0;
      rd(OFS_STATUS);
      chk("pd_clear", 8'h00, rd_q);
      hlt(2'h3);
      wdt_ovf <= 1'b1;
      @(posedge aclk);
      wdt_ovf <= 1'b0;
      do @(posedge aclk); while (pc_sp_reset_q !== 1'b1);
      rd(OFS_STATUS);
      chk("timeout", 8'h03, rd_q);
      hlt(2'h3);
      rst_pin_n <= 1'b0;
      do @(posedge aclk); while (full_reset_q !== 1'b1);
      rst_pin_n <= 1'b1;
      rd(OFS_WAKE_CAUSE);
      chk("cause", 8'h01, rd_q);
      $display("test power down done");
      results();
   end
endmodule : tb_top
